// ===== shared/iepb_defines.vh
// Register offsets, field layouts and reset values of the enable and priority bank
`ifndef IEPB_DEFINES_VH
`define IEPB_DEFINES_VH
`define IEPB_OFS_EN2      8'h00
`define IEPB_OFS_EN3      8'h04
`define IEPB_OFS_EN4      8'h08
`define IEPB_OFS_EN5      8'h0C
`define IEPB_OFS_EN6      8'h10
`define IEPB_OFS_PRI0     8'h14
`define IEPB_OFS_PRI1     8'h18
`define IEPB_OFS_PRI2     8'h1C
`define IEPB_OFS_FLAG     8'h20
`define IEPB_OFS_STATUS   8'h24
`define IEPB_OFS_MASK     8'h28
`define IEPB_MASK_EN2     16'h0001
`define IEPB_MASK_EN3     16'h4066
`define IEPB_MASK_EN4     16'h210E
`define IEPB_MASK_EN5     16'h3FFE
`define IEPB_MASK_EN6     16'h0010
`define IEPB_MASK_PRI0    16'h7777
`define IEPB_MASK_PRI1    16'h7770
`define IEPB_MASK_PRI2    16'h7777
`define IEPB_RST_EN       16'h0000
`define IEPB_RST_PRI0     16'h4444
`define IEPB_RST_PRI1     16'h4440
`define IEPB_RST_PRI2     16'h4444
`define IEPB_PRI_OFF      3'h0
`define IEPB_PRI_W        3
`define IEPB_NSRC         12
`endif

// ===== rtl/iepb_src_gate.v
// One source gate: flag, enable and priority to a forwarded level
`timescale 1ns/100ps
module iepb_src_gate (
  input  wire       flag_in,   // Pending flag of the source
  input  wire       en_in,     // Enable bit
  input  wire [2:0] pri_in,    // Priority field
  output wire       req_out,   // Request forwarded
  output wire [2:0] level_out  // Level carried, zero when not forwarded
);
  // Code 000 disables regardless of enable
  assign req_out   = flag_in & en_in & (pri_in != 3'h0);
  // Codes 001..111 map straight to levels 1..7
  assign level_out = req_out ? pri_in : 3'h0;
endmodule

// ===== rtl/iepb_top.v
// Interrupt enable and priority register bank with Wishbone slave
`timescale 1ns/100ps
`include "iepb_defines.vh"
module iepb_top (
  input  wire        clk_sys_in,    // 200 MHz system clock
  input  wire        rst_n_in,      // Async reset, active low
  input  wire        ce_in,         // Clock enable, freezes all state when low
  input  wire        wb_cyc_in,     // Wishbone cycle
  input  wire        wb_stb_in,     // Wishbone strobe
  input  wire        wb_we_in,      // Wishbone write enable
  input  wire [7:0]  wb_adr_in,     // Wishbone byte address
  input  wire [3:0]  wb_sel_in,     // Wishbone byte selects
  input  wire [31:0] wb_dat_in,     // Wishbone write data
  output reg  [31:0] wb_dat_out,    // Wishbone read data
  output reg         wb_ack_out,    // Wishbone acknowledge
  input  wire [11:0] src_req_in,    // Source request pulses, same clock
  output reg  [11:0] fwd_req_out,   // Forwarded requests to the core
  output reg  [2:0]  fwd_level_out, // Highest forwarded level
  output reg         irq_out        // Level interrupt, unmasked status set
);
  // Source order: 0 ext0, 1 cap1, 2 cmp1, 3 timer a, 4 cap2, 5 cmp2, 6 timer b,
  // 7 timer c, 8 spi a fault, 9 spi a event, 10 uart a rx, 11 spi b fault
  reg  [15:0] enable_2;
  reg  [15:0] irq_enable_3;
  reg  [15:0] irq_enable_4;
  reg  [15:0] irq_enable_5;
  reg  [15:0] irq_enable_6;
  reg  [15:0] irq_priority_0;
  reg  [15:0] irq_priority_1;
  reg  [15:0] irq_priority_2;
  reg  [11:0] src_flag;
  reg  [1:0]  evt_status;
  reg  [1:0]  evt_mask;
  reg  [11:0] fwd_prev;
  wire [11:0] src_en;
  wire [35:0] src_pri;
  wire [11:0] gate_req;
  wire [35:0] gate_level;
  wire        bus_req;
  wire        wr_en;
  wire        rd_en;
  wire [15:0] wdat;
  wire [15:0] lane_mask;
  reg  [15:0] next_rdat;
  reg  [2:0]  next_level;
  reg         next_ack;
  wire [1:0]  evt_set;
  wire        bad_adr;
  integer     i;

  // Only sources with an enable bit in this bank carry a real enable
  // Others have their enables elsewhere; they pass on priority only
  assign src_en = {enable_2[0], 11'h7FF};
  assign src_pri = {irq_priority_0[14:12], irq_priority_2[14:12], irq_priority_2[10:8],
                    irq_priority_2[6:4], irq_priority_2[2:0], irq_priority_1[14:12],
                    irq_priority_1[10:8], irq_priority_1[6:4], irq_priority_0[14:12],
                    irq_priority_0[10:8], irq_priority_0[6:4], irq_priority_0[2:0]};

  genvar g;
  generate
    for (g = 0; g < `IEPB_NSRC; g = g + 1) begin : gen_gate
      iepb_src_gate u_gate (
        .flag_in   (src_flag[g]),
        .en_in     (src_en[g]),
        .pri_in    (src_pri[3*g +: 3]),
        .req_out   (gate_req[g]),
        .level_out (gate_level[3*g +: 3])
      );
    end
  endgenerate

  assign bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_en     = bus_req & wb_we_in & ce_in;
  assign rd_en     = bus_req & ~wb_we_in;
  assign wdat      = wb_dat_in[15:0];
  assign lane_mask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign bad_adr   = (wb_adr_in > `IEPB_OFS_MASK) | (wb_adr_in[1:0] != 2'h0);
  // Status event 0: a request newly forwarded; event 1: unmapped access
  assign evt_set   = {bus_req & bad_adr, |(gate_req & ~fwd_prev)};

  always @* begin
    next_level = 3'h0;
    for (i = 0; i < `IEPB_NSRC; i = i + 1) begin
      if (gate_level[3*i +: 3] > next_level) begin
        next_level = gate_level[3*i +: 3];
      end
    end
  end

  // Unimplemented bits masked on read
  always @* begin
    next_rdat = 16'h0000;
    case (wb_adr_in)
      `IEPB_OFS_EN2:    next_rdat = enable_2 & `IEPB_MASK_EN2;
      `IEPB_OFS_EN3:    next_rdat = irq_enable_3 & `IEPB_MASK_EN3;
      `IEPB_OFS_EN4:    next_rdat = irq_enable_4 & `IEPB_MASK_EN4;
      `IEPB_OFS_EN5:    next_rdat = irq_enable_5 & `IEPB_MASK_EN5;
      `IEPB_OFS_EN6:    next_rdat = irq_enable_6 & `IEPB_MASK_EN6;
      `IEPB_OFS_PRI0:   next_rdat = irq_priority_0 & `IEPB_MASK_PRI0;
      `IEPB_OFS_PRI1:   next_rdat = irq_priority_1 & `IEPB_MASK_PRI1;
      `IEPB_OFS_PRI2:   next_rdat = irq_priority_2 & `IEPB_MASK_PRI2;
      `IEPB_OFS_FLAG:   next_rdat = {4'h0, src_flag};
      `IEPB_OFS_STATUS: next_rdat = {14'h0, evt_status};
      `IEPB_OFS_MASK:   next_rdat = {14'h0, evt_mask};
      default:          next_rdat = 16'h0000;
    endcase
  end

  always @* begin
    next_ack = bus_req;
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_2       <= `IEPB_RST_EN;
      irq_enable_3   <= `IEPB_RST_EN;
      irq_enable_4   <= `IEPB_RST_EN;
      irq_enable_5   <= `IEPB_RST_EN;
      irq_enable_6   <= `IEPB_RST_EN;
      irq_priority_0 <= `IEPB_RST_PRI0;
      irq_priority_1 <= `IEPB_RST_PRI1;
      irq_priority_2 <= `IEPB_RST_PRI2;
      src_flag       <= 12'h000;
      evt_status     <= 2'h0;
      evt_mask       <= 2'h0;
      fwd_prev       <= 12'h000;
      wb_ack_out     <= 1'b0;
      wb_dat_out     <= 32'h00000000;
      fwd_req_out    <= 12'h000;
      fwd_level_out  <= 3'h0;
      irq_out        <= 1'b0;
    end else if (ce_in) begin
      wb_ack_out <= next_ack;
      if (rd_en) begin
        wb_dat_out <= {16'h0000, next_rdat};
      end
      // Writes touch only implemented bits in selected lanes
      if (wr_en) begin
        case (wb_adr_in)
          `IEPB_OFS_EN2:  enable_2 <= (enable_2 & ~lane_mask) | (wdat & lane_mask
                                       & `IEPB_MASK_EN2);
          `IEPB_OFS_EN3:  irq_enable_3 <= (irq_enable_3 & ~lane_mask) | (wdat & lane_mask
                                           & `IEPB_MASK_EN3);
          `IEPB_OFS_EN4:  irq_enable_4 <= (irq_enable_4 & ~lane_mask) | (wdat & lane_mask
                                           & `IEPB_MASK_EN4);
          `IEPB_OFS_EN5:  irq_enable_5 <= (irq_enable_5 & ~lane_mask) | (wdat & lane_mask
                                           & `IEPB_MASK_EN5);
          `IEPB_OFS_EN6:  irq_enable_6 <= (irq_enable_6 & ~lane_mask) | (wdat & lane_mask
                                           & `IEPB_MASK_EN6);
          `IEPB_OFS_PRI0: irq_priority_0 <= (irq_priority_0 & ~lane_mask) | (wdat & lane_mask
                                             & `IEPB_MASK_PRI0);
          `IEPB_OFS_PRI1: irq_priority_1 <= (irq_priority_1 & ~lane_mask) | (wdat & lane_mask
                                             & `IEPB_MASK_PRI1);
          `IEPB_OFS_PRI2: irq_priority_2 <= (irq_priority_2 & ~lane_mask) | (wdat & lane_mask
                                             & `IEPB_MASK_PRI2);
          `IEPB_OFS_MASK: if (wb_sel_in[0]) begin
            evt_mask <= wdat[1:0];
          end
          default: ;
        endcase
      end
      // Hardware set wins over a software write in the same cycle
      if (wr_en && wb_adr_in == `IEPB_OFS_FLAG) begin
        src_flag <= (src_flag & ~lane_mask[11:0]) | (wdat[11:0] & lane_mask[11:0]) | src_req_in;
      end else begin
        src_flag <= src_flag | src_req_in;
      end
      // Write one to clear; new events win
      if (wr_en && wb_adr_in == `IEPB_OFS_STATUS && wb_sel_in[0]) begin
        evt_status <= (evt_status & ~wdat[1:0]) | evt_set;
      end else begin
        evt_status <= evt_status | evt_set;
      end
      fwd_prev      <= gate_req;
      fwd_req_out   <= gate_req;
      fwd_level_out <= next_level;
      irq_out       <= |(((evt_status | evt_set) & evt_mask));
    end
  end
endmodule

// ===== verif/iepb_props.sv
// Concurrent checks on the bank's bus and forwarding ports
`timescale 1ns/100ps
`include "iepb_defines.vh"
module iepb_props (
  input logic        clk_sys_in,    // Clock
  input logic        rst_n_in,      // Reset, active low
  input logic        ce_in,         // Clock enable
  input logic        wb_cyc_in,     // Cycle
  input logic        wb_stb_in,     // Strobe
  input logic        wb_we_in,      // Write
  input logic [7:0]  wb_adr_in,     // Address
  input logic [31:0] wb_dat_out,    // Read data
  input logic        wb_ack_out,    // Acknowledge
  input logic [11:0] fwd_req_out,   // Forwarded requests
  input logic [2:0]  fwd_level_out  // Forwarded level
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("ack late");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
    else $error("ack without strobe");
  rd_upper_a: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read half set");
  en6_unimpl_a: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == `IEPB_OFS_EN6 |-> wb_dat_out[15:0] == 16'h0010
    || wb_dat_out[15:0] == 16'h0000) else $error("enable six spare bits set");
  pri1_low_a: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == `IEPB_OFS_PRI1 |-> wb_dat_out[3:0] == 4'h0)
    else $error("priority one low nibble set");
  unmapped_zero_a: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in > `IEPB_OFS_MASK |-> wb_dat_out == 32'h0)
    else $error("unmapped read nonzero");
  lvl_idle_a: assert property (fwd_req_out == 12'h000 |-> fwd_level_out == 3'h0)
    else $error("level without request");
  lvl_live_a: assert property (fwd_req_out != 12'h000 |-> fwd_level_out != 3'h0)
    else $error("request at level zero");
  cover property (wb_ack_out && !wb_we_in);
  cover property (wb_ack_out && wb_we_in);
  cover property (fwd_level_out == 3'h7);
endmodule
bind iepb_top iepb_props iepb_props_i (.clk_sys_in, .rst_n_in, .ce_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .fwd_req_out, .fwd_level_out);

// ===== verif/iepb_src_model.sv
// Peripheral request sources feeding the bank
`timescale 1ns/100ps
module iepb_src_model (
  input  wire logic   clk_in,  // System clock
  output logic [11:0] req_out  // Request pulses
);
  initial req_out = 12'h000;
  // External sources taken as already routed to a remappable pin
  // One-cycle pulse, moved only just after an edge
  task automatic fire(input int k);
    @(posedge clk_in);
    req_out[k] <= 1'b1;
    @(posedge clk_in);
    req_out[k] <= 1'b0;
  endtask
endmodule

// ===== verif/testbench.sv
// Register, forwarding and interrupt tests of the bank
`timescale 1ns/100ps
`include "iepb_defines.vh"
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        ce = 1'b1;
  logic [3:0]  sel = 4'h3;
  logic [3:0]  sel_q = 4'h3;
  wire  [31:0] rdat;
  wire         ack;
  wire  [11:0] src;
  wire  [11:0] fwd;
  wire  [2:0]  lvl;
  wire         irq;
  logic [31:0] d;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [15:0] rstv [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4444, 16'h4440, 16'h4444};
  logic [15:0] msk [8] = '{16'h0001, 16'h4066, 16'h210E, 16'h3FFE, 16'h0010, 16'h7777,
                           16'h7770, 16'h7777};
  iepb_top iepb_top_i (.clk_sys_in, .rst_n_in, .ce_in(ce), .wb_cyc_in(req), .wb_stb_in(req),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .src_req_in(src), .fwd_req_out(fwd), .fwd_level_out(lvl), .irq_out(irq));
  iepb_src_model iepb_src_model_i (.clk_in(clk_sys_in), .req_out(src));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= sel_q;
    do @(posedge clk_sys_in); while (ack !== 1'b1);
    d = rdat;
    req <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs settle one edge after a register or flag change
  task automatic fw(input logic i, input logic [11:0] f, input logic [2:0] l);
    repeat (3) @(posedge clk_sys_in);
    chk({16'h0, irq, fwd, lvl}, {16'h0, i, f, l});
  endtask
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (logic [3:0] i = 0; i < 8; i++) begin
      xfer(1'b0, {2'b00, i, 2'b00}, 32'h0);
      chk(d, {16'h0, rstv[i]});
      xfer(1'b1, {2'b00, i, 2'b00}, 32'hFFFF_FFFF);
      xfer(1'b0, {2'b00, i, 2'b00}, 32'h0);
      chk(d, {16'h0, msk[i]});
    end
    xfer(1'b1, 8'h30, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h30, 32'h0);
    chk(d, 32'h0);
    xfer(1'b0, 8'h15, 32'h0);
    chk(d, 32'h0);
    // Unmapped and misaligned accesses leave status event one pending
    xfer(1'b0, `IEPB_OFS_STATUS, 32'h0);
    chk(d, 32'h2);
    // Low lane only: the high byte must survive
    sel_q = 4'h1;
    xfer(1'b1, `IEPB_OFS_PRI1, 32'h0);
    sel_q = 4'h3;
    xfer(1'b0, `IEPB_OFS_PRI1, 32'h0);
    chk(d, 32'h7700);
    xfer(1'b1, `IEPB_OFS_STATUS, 32'hFFFF);
    xfer(1'b1, `IEPB_OFS_MASK, 32'h1);
    xfer(1'b1, `IEPB_OFS_PRI0, 32'h0);
    iepb_src_model_i.fire(0);
    // Clock enable low: a pulse in that window must not set a flag
    ce <= 1'b0;
    iepb_src_model_i.fire(5);
    ce <= 1'b1;
    xfer(1'b0, `IEPB_OFS_FLAG, 32'h0);
    chk(d, 32'h1);
    for (logic [3:0] l = 0; l < 8; l++) begin
      xfer(1'b1, `IEPB_OFS_PRI0, {28'h0, l});
      fw(l != 0, {11'h0, l != 0}, l[2:0]);
    end
    // Masking hides the pending status, clearing it drops the line
    xfer(1'b1, `IEPB_OFS_MASK, 32'h0);
    fw(1'b0, 12'h001, 3'h7);
    xfer(1'b1, `IEPB_OFS_MASK, 32'h1);
    fw(1'b1, 12'h001, 3'h7);
    xfer(1'b1, `IEPB_OFS_STATUS, 32'h1);
    fw(1'b0, 12'h001, 3'h7);
    xfer(1'b1, `IEPB_OFS_EN2, 32'h0);
    xfer(1'b1, `IEPB_OFS_PRI0, 32'h7002);
    iepb_src_model_i.fire(11);
    fw(1'b0, 12'h001, 3'h2);
    xfer(1'b1, `IEPB_OFS_EN2, 32'h1);
    fw(1'b1, 12'h801, 3'h7);
    xfer(1'b1, `IEPB_OFS_PRI0, 32'h0);
    fw(1'b1, 12'h000, 3'h0);
    xfer(1'b1, `IEPB_OFS_FLAG, 32'h0);
    xfer(1'b0, `IEPB_OFS_FLAG, 32'h0);
    chk(d, 32'h0);
    // Reset again in mid-run: registers and outputs back to their reset state
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    xfer(1'b0, `IEPB_OFS_PRI0, 32'h0);
    chk(d, {16'h0, `IEPB_RST_PRI0});
    fw(1'b0, 12'h000, 3'h0);
    finish_test();
  end
endmodule
